/* rtl/nvmdac_array.sv */
// Nonvolatile byte store with registered read port.
// Assumes a single writer; contents are not touched by reset.
`timescale 1ns/10ps
`default_nettype none
`include "nvmdac_cfg.svh"
module nvmdac_array #(
  parameter int DEPTH = `NVMDAC_DEPTH,
  parameter int AW    = `NVMDAC_AW,
  parameter int DW    = `NVMDAC_DW
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          reset,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] cells [DEPTH];

  always_ff @(posedge mclk) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata <= '0;
    end else begin
      rdata <= cells[raddr];
    end
  end
endmodule : nvmdac_array
`default_nettype wire

/* rtl/nvmdac_cfg.svh */
// Offsets, field positions, reset values and timing counts of the nonvolatile data controller.
// Included by the design modules and the bench; definitions only.
`ifndef NVMDAC_CFG_SVH
`define NVMDAC_CFG_SVH

// Data memory offsets of the block's registers
`define NVMDAC_CTRL_OFF      8'h40
`define NVMDAC_ADDR_OFF      8'h1E
`define NVMDAC_DATA_OFF      8'h1F
`define NVMDAC_BANK_OFF      8'h04
`define NVMDAC_IRQ_OFF       8'h0E

// Control register fields
`define NVMDAC_PROG_ALLOW    3
`define NVMDAC_PROG_GO       2
`define NVMDAC_FETCH_ALLOW   1
`define NVMDAC_FETCH_GO      0

// Interrupt register fields
`define NVMDAC_IRQ_ENABLE    0
`define NVMDAC_IRQ_FLAG      1

// Reset values
`define NVMDAC_CTRL_RST      4'h0
`define NVMDAC_BANK_RST      1'h0
`define NVMDAC_ADDR_RST      6'h00
`define NVMDAC_DATA_RST      8'h00

// Store length in internal timer edges, fetch length in system cycles
`define NVMDAC_STORE_TICKS   4
`define NVMDAC_FETCH_CYCLES  3

// Store geometry
`define NVMDAC_DEPTH         64
`define NVMDAC_AW            6
`define NVMDAC_DW            8

`endif

/* rtl/nvmdac_pkg.sv */
// Types shared by the nonvolatile data controller.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package nvmdac_pkg;

  typedef enum logic [2:0] {
    NVMDAC_IDLE  = 3'b001,
    NVMDAC_FETCH = 3'b010,
    NVMDAC_STORE = 3'b100
  } nvmdac_state_t;

endpackage : nvmdac_pkg
`default_nettype wire

/* rtl/nvmdac_sync.sv */
// Two-flop synchroniser with rising edge pulse.
// Assumes din is asynchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
module nvmdac_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  // Asynchronous level in, pulse out
  input  wire logic din,
  output logic      rise
);
  logic meta;
  logic sync;
  logic last;

  always_ff @(posedge mclk) begin
    if (reset) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
      rise <= 1'b0;
    end else begin
      meta <= din;
      sync <= meta;
      last <= sync;
      rise <= sync & ~last;
    end
  end
endmodule : nvmdac_sync
`default_nettype wire

/* rtl/nvmdac_top.sv */
// Nonvolatile data controller: bank-aware register port, fetch and store sequencing,
// completion interrupt. Assumes the CPU presents one data memory access per cycle at most
// and that the store timer clock pin is asynchronous to mclk.
//
// Behaviour
// - Holds 64 bytes of nonvolatile storage, reachable only through registers.
// - Single-byte accesses; address and data in bank 0, control in bank 1.
// - Address register holds six bits; bits 7 and 6 read zero.
// - Control bits at 3..0 reset to zero; bits 7..4 read zero.
// - Store starts only when prog_go is set with prog_allow already high.
// - Hardware clears prog_go when the store completes.
// - Fetch starts only when fetch_go is set with fetch_allow already high.
// - Fetch end clears fetch_go and loads fetched byte into data register.
// - Data register keeps the fetched byte until the next fetch or data register write.
// - Store length follows an internal timer asynchronous to mclk.
// - Reset clears prog_allow, blocking stores until re-enabled.
// - Completion sets the block flag and the multi-function request flag.
// - Vector only with all three enables set and stack not full.
// - Service clears only the multi-function flag; software clears the block flag.
// - Cleared allow bits block their operations.
// - Bank select bit 0 picks bank 0 or 1, resets to zero.
// - Port-one indirect accesses follow bank select; others reach bank 0.
`timescale 1ns/10ps
`default_nettype none
`include "nvmdac_cfg.svh"
module nvmdac_top
  import nvmdac_pkg::*;
#(
  parameter int STORE_TICKS  = `NVMDAC_STORE_TICKS,
  parameter int FETCH_CYCLES = `NVMDAC_FETCH_CYCLES
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // Data memory access from the CPU
  input  wire logic [7:0] dm_addr,
  input  wire logic       dm_via_port_one,
  input  wire logic       dm_wr,
  input  wire logic       dm_rd,
  input  wire logic [7:0] dm_wdata,
  output logic      [7:0] dm_rdata,
  // Store timer clock pin
  input  wire logic       prog_timer_clk,
  // Interrupt controller side
  input  wire logic       mf_enable,
  input  wire logic       global_enable,
  input  wire logic       stack_full,
  input  wire logic       irq_service_ack,
  output logic            mf_irq_req,
  output logic            irq_vector_req
);

  localparam int AW = `NVMDAC_AW;
  localparam int DW = `NVMDAC_DW;

  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off,
                                   input logic bank, input logic want, input logic any);
    return (a == off) && (any || (bank == want));
  endfunction : reg_hit

  nvmdac_state_t state;
  logic [7:0]    cnt;
  logic          bank_select;
  logic [AW-1:0] addr_reg;
  logic [DW-1:0] data_reg;
  logic          prog_allow;
  logic          prog_go;
  logic          fetch_allow;
  logic          fetch_go;
  logic          store_armed;
  logic          irq_enable;
  logic          irq_flag;
  logic [AW-1:0] op_addr;
  logic [DW-1:0] op_byte;
  logic [DW-1:0] mem_rdata;
  logic          timer_tick;

  // Bank in effect for this access
  logic eff_bank;
  logic sel_ctrl, sel_addr, sel_data, sel_bank, sel_irq;
  logic wr_ctrl, wr_addr, wr_data, wr_bank, wr_irq;
  logic start_store, start_fetch, store_done, fetch_done, fetch_abort, op_done;

  assign eff_bank = dm_via_port_one & bank_select;
  assign sel_ctrl = reg_hit(dm_addr, `NVMDAC_CTRL_OFF, eff_bank, 1'b1, 1'b0);
  assign sel_addr = reg_hit(dm_addr, `NVMDAC_ADDR_OFF, eff_bank, 1'b0, 1'b0);
  assign sel_data = reg_hit(dm_addr, `NVMDAC_DATA_OFF, eff_bank, 1'b0, 1'b0);
  assign sel_bank = reg_hit(dm_addr, `NVMDAC_BANK_OFF, eff_bank, 1'b0, 1'b1);
  assign sel_irq  = reg_hit(dm_addr, `NVMDAC_IRQ_OFF, eff_bank, 1'b0, 1'b1);

  assign wr_ctrl = dm_wr & sel_ctrl;
  assign wr_addr = dm_wr & sel_addr;
  assign wr_data = dm_wr & sel_data;
  assign wr_bank = dm_wr & sel_bank;
  assign wr_irq  = dm_wr & sel_irq;

  // Start decisions use the allow bits as they stood before this write
  assign start_store = wr_ctrl & dm_wdata[`NVMDAC_PROG_GO] & ~prog_go
                       & prog_allow & store_armed
                       & ~dm_wdata[`NVMDAC_FETCH_GO] & (state == NVMDAC_IDLE);
  assign start_fetch = wr_ctrl & dm_wdata[`NVMDAC_FETCH_GO] & ~fetch_go
                       & fetch_allow
                       & ~dm_wdata[`NVMDAC_PROG_GO] & (state == NVMDAC_IDLE);

  assign store_done  = (state == NVMDAC_STORE) & timer_tick
                       & (cnt == 8'(STORE_TICKS - 1));
  assign fetch_abort = (state == NVMDAC_FETCH) & ~fetch_allow;
  assign fetch_done  = (state == NVMDAC_FETCH) & fetch_allow
                       & (cnt == 8'(FETCH_CYCLES - 1));
  assign op_done     = store_done | fetch_done;

  nvmdac_sync u_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   (prog_timer_clk),
    .rise  (timer_tick)
  );

  // Commit happens at the end of the timed cycle
  nvmdac_array #(
    .DEPTH (`NVMDAC_DEPTH),
    .AW    (AW),
    .DW    (DW)
  ) u_array (
    .mclk  (mclk),
    .reset (reset),
    .we    (store_done),
    .waddr (op_addr),
    .wdata (op_byte),
    .raddr (op_addr),
    .rdata (mem_rdata)
  );

  // Sequencer
  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= NVMDAC_IDLE;
      cnt   <= 8'h00;
    end else begin
      unique case (state)
        NVMDAC_IDLE: begin
          cnt <= 8'h00;
          if (start_store) begin
            state <= NVMDAC_STORE;
          end else if (start_fetch) begin
            state <= NVMDAC_FETCH;
          end
        end
        NVMDAC_FETCH: begin
          cnt <= cnt + 8'h01;
          if (fetch_done || fetch_abort) begin
            state <= NVMDAC_IDLE;
          end
        end
        NVMDAC_STORE: begin
          if (store_done) begin
            state <= NVMDAC_IDLE;
          end else if (timer_tick) begin
            cnt <= cnt + 8'h01;
          end
        end
      endcase
    end
  end

  // Operation address and byte latched at start
  always_ff @(posedge mclk) begin
    if (reset) begin
      op_addr <= `NVMDAC_ADDR_RST;
      op_byte <= `NVMDAC_DATA_RST;
    end else if (start_store || start_fetch) begin
      op_addr <= addr_reg;
      op_byte <= data_reg;
    end
  end

  // Control register
  always_ff @(posedge mclk) begin
    if (reset) begin
      {prog_allow, prog_go, fetch_allow, fetch_go} <= `NVMDAC_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        prog_allow  <= dm_wdata[`NVMDAC_PROG_ALLOW];
        fetch_allow <= dm_wdata[`NVMDAC_FETCH_ALLOW];
      end
      if (store_done) begin
        prog_go <= 1'b0;
      end else if (start_store) begin
        prog_go <= 1'b1;
      end
      if (fetch_done || fetch_abort) begin
        fetch_go <= 1'b0;
      end else if (start_fetch) begin
        fetch_go <= 1'b1;
      end
    end
  end

  // Store arms only on the access right after prog_allow rises
  always_ff @(posedge mclk) begin
    if (reset) begin
      store_armed <= 1'b0;
    end else if (wr_ctrl && dm_wdata[`NVMDAC_PROG_ALLOW] && !prog_allow) begin
      store_armed <= 1'b1;
    end else if (dm_wr || dm_rd) begin
      store_armed <= 1'b0;
    end
  end

  // Bank select, address and data registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      bank_select <= `NVMDAC_BANK_RST;
    end else if (wr_bank) begin
      bank_select <= dm_wdata[0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      addr_reg <= `NVMDAC_ADDR_RST;
    end else if (wr_addr) begin
      addr_reg <= dm_wdata[AW-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      data_reg <= `NVMDAC_DATA_RST;
    end else if (fetch_done) begin
      data_reg <= mem_rdata;
    end else if (wr_data) begin
      data_reg <= dm_wdata;
    end
  end

  // Interrupt flags; hardware set wins over clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_enable <= 1'b0;
      irq_flag   <= 1'b0;
      mf_irq_req <= 1'b0;
    end else begin
      if (wr_irq) begin
        irq_enable <= dm_wdata[`NVMDAC_IRQ_ENABLE];
      end
      if (op_done) begin
        irq_flag <= 1'b1;
      end else if (wr_irq) begin
        irq_flag <= dm_wdata[`NVMDAC_IRQ_FLAG];
      end
      if (op_done) begin
        mf_irq_req <= 1'b1;
      end else if (irq_service_ack) begin
        mf_irq_req <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_vector_req <= 1'b0;
    end else begin
      irq_vector_req <= mf_irq_req & irq_enable & mf_enable
                        & global_enable & ~stack_full;
    end
  end

  // Read port
  always_ff @(posedge mclk) begin
    if (reset) begin
      dm_rdata <= 8'h00;
    end else if (dm_rd) begin
      if (sel_ctrl) begin
        dm_rdata <= {4'h0, prog_allow, prog_go, fetch_allow, fetch_go};
      end else if (sel_addr) begin
        dm_rdata <= {2'h0, addr_reg};
      end else if (sel_data) begin
        dm_rdata <= data_reg;
      end else if (sel_bank) begin
        dm_rdata <= {7'h00, bank_select};
      end else if (sel_irq) begin
        dm_rdata <= {6'h00, irq_flag, irq_enable};
      end else begin
        dm_rdata <= 8'h00;
      end
    end else begin
      dm_rdata <= 8'h00;
    end
  end

  // Checks
  logic last_rd_ctrl;
  logic last_rd_addr;
  always_ff @(posedge mclk) begin
    if (reset) begin
      last_rd_ctrl <= 1'b0;
      last_rd_addr <= 1'b0;
    end else begin
      last_rd_ctrl <= dm_rd & sel_ctrl;
      last_rd_addr <= dm_rd & sel_addr;
    end
  end

  property p_ctrl_high_zero;
    @(posedge mclk) disable iff (reset) last_rd_ctrl |-> dm_rdata[7:4] == 4'h0;
  endproperty
  a_ctrl_high_zero: assert property (p_ctrl_high_zero) else $error("ctrl high bits set");

  property p_addr_high_zero;
    @(posedge mclk) disable iff (reset) last_rd_addr |-> dm_rdata[7:6] == 2'h0;
  endproperty
  a_addr_high_zero: assert property (p_addr_high_zero) else $error("addr high bits set");

  property p_store_needs_allow;
    @(posedge mclk) disable iff (reset)
      $rose(prog_go) |-> $past(prog_allow) && $past(store_armed) && state == NVMDAC_STORE;
  endproperty
  a_store_needs_allow: assert property (p_store_needs_allow) else $error("store unguarded");

  property p_prog_go_clears;
    @(posedge mclk) disable iff (reset) store_done |=> !prog_go && state == NVMDAC_IDLE;
  endproperty
  a_prog_go_clears: assert property (p_prog_go_clears) else $error("prog_go stuck");

  property p_fetch_needs_allow;
    @(posedge mclk) disable iff (reset) $rose(fetch_go) |-> $past(fetch_allow);
  endproperty
  a_fetch_needs_allow: assert property (p_fetch_needs_allow) else $error("fetch unguarded");

  property p_fetch_result;
    @(posedge mclk) disable iff (reset)
      fetch_done |=> !fetch_go && data_reg == $past(mem_rdata);
  endproperty
  a_fetch_result: assert property (p_fetch_result) else $error("fetch result wrong");

  property p_data_holds;
    @(posedge mclk) disable iff (reset) !fetch_done && !wr_data |=> $stable(data_reg);
  endproperty
  a_data_holds: assert property (p_data_holds) else $error("data register changed");

  property p_fetch_latency;
    @(posedge mclk) disable iff (reset)
      start_fetch ##1 fetch_allow [*3] |=> !fetch_go;
  endproperty
  a_fetch_latency: assert property (p_fetch_latency) else $error("fetch too slow");

  property p_store_timed;
    @(posedge mclk) disable iff (reset) start_store |=> !timer_tick [*1] or prog_go;
  endproperty
  a_store_timed: assert property (p_store_timed) else $error("store ended untimed");

  property p_flags_set;
    @(posedge mclk) disable iff (reset) op_done |=> irq_flag && mf_irq_req;
  endproperty
  a_flags_set: assert property (p_flags_set) else $error("completion flags missing");

  property p_vector_gate;
    @(posedge mclk) disable iff (reset)
      irq_vector_req |-> $past(irq_enable && mf_enable && global_enable && !stack_full);
  endproperty
  a_vector_gate: assert property (p_vector_gate) else $error("vector without enables");

  property p_service_keeps_flag;
    @(posedge mclk) disable iff (reset)
      irq_service_ack && !wr_irq && irq_flag |=> irq_flag;
  endproperty
  a_service_keeps_flag: assert property (p_service_keeps_flag) else $error("flag lost");

  property p_ctrl_bank;
    @(posedge mclk) disable iff (reset) wr_ctrl |-> dm_via_port_one && bank_select;
  endproperty
  a_ctrl_bank: assert property (p_ctrl_bank) else $error("ctrl reached from bank 0");

  c_store:  cover property (@(posedge mclk) disable iff (reset) store_done);
  c_fetch:  cover property (@(posedge mclk) disable iff (reset) fetch_done);
  c_vector: cover property (@(posedge mclk) disable iff (reset) irq_vector_req);
  c_refuse: cover property (@(posedge mclk) disable iff (reset)
                            wr_ctrl && dm_wdata[`NVMDAC_PROG_GO] && !start_store);

endmodule : nvmdac_top
`default_nettype wire

/* verification/test_nvmdac_top.sv */
// Self-checking bench for the nonvolatile data controller top.
// Assumes the design files and nvmdac_cfg.svh are compiled ahead of this file.
`timescale 1ns/10ps
`default_nettype none
`include "nvmdac_cfg.svh"
module test_nvmdac_top;
  localparam int STORE_TICKS  = 2;
  localparam int FETCH_CYCLES = 3;

  logic       mclk            = 1'b0;
  logic       reset           = 1'b1;
  logic [7:0] dm_addr         = 8'h00;
  logic       dm_via_port_one = 1'b0;
  logic       dm_wr           = 1'b0;
  logic       dm_rd           = 1'b0;
  logic [7:0] dm_wdata        = 8'h00;
  logic [7:0] dm_rdata;
  logic       prog_timer_clk  = 1'b0;
  logic       mf_enable       = 1'b0;
  logic       global_enable   = 1'b0;
  logic       stack_full      = 1'b0;
  logic       irq_service_ack = 1'b0;
  logic       mf_irq_req;
  logic       irq_vector_req;
  int         errors          = 0;
  int         samples_checked = 0;
  logic [7:0] v;

  nvmdac_top #(.STORE_TICKS(STORE_TICKS), .FETCH_CYCLES(FETCH_CYCLES)) u_nvmdac_top (
    .mclk(mclk), .reset(reset), .dm_addr(dm_addr), .dm_via_port_one(dm_via_port_one),
    .dm_wr(dm_wr), .dm_rd(dm_rd), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata),
    .prog_timer_clk(prog_timer_clk), .mf_enable(mf_enable), .global_enable(global_enable),
    .stack_full(stack_full), .irq_service_ack(irq_service_ack), .mf_irq_req(mf_irq_req),
    .irq_vector_req(irq_vector_req));

  initial begin
    forever #50 mclk = ~mclk;
  end

  // Free running store timer, unrelated in phase to mclk
  initial begin
    #37;
    forever #730 prog_timer_clk = ~prog_timer_clk;
  end

  task automatic conclude;
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic via, input logic [7:0] d);
    @(posedge mclk) #1;
    dm_addr = a;
    dm_via_port_one = via;
    dm_wdata = d;
    dm_wr = 1'b1;
    @(posedge mclk) #1;
    dm_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic via, output logic [7:0] d);
    @(posedge mclk) #1;
    dm_addr = a;
    dm_via_port_one = via;
    dm_rd = 1'b1;
    @(posedge mclk) #1;
    dm_rd = 1'b0;
    d = dm_rdata;
  endtask : rd

  // Poll the control register until the given go bit drops
  task automatic wait_go(input int bit_pos, input string name);
    int n;
    n = 0;
    rd(`NVMDAC_CTRL_OFF, 1'b1, v);
    while (v[bit_pos] !== 1'b0 && n < 60) begin
      rd(`NVMDAC_CTRL_OFF, 1'b1, v);
      n++;
    end
    chk(name, {7'h00, v[bit_pos]}, 8'h00);
  endtask : wait_go

  task automatic store(input logic [7:0] a, input logic [7:0] d);
    wr(`NVMDAC_ADDR_OFF, 1'b0, a);
    wr(`NVMDAC_DATA_OFF, 1'b0, d);
    wr(`NVMDAC_CTRL_OFF, 1'b1, 8'h08);
    wr(`NVMDAC_CTRL_OFF, 1'b1, 8'h0C);
    rd(`NVMDAC_CTRL_OFF, 1'b1, v);
    chk("store_started", v, 8'h0C);
    wait_go(2, "store_go_clear");
    wr(`NVMDAC_CTRL_OFF, 1'b1, 8'h00);
  endtask : store

  task automatic fetch(input logic [7:0] a, input logic [7:0] exp);
    wr(`NVMDAC_ADDR_OFF, 1'b0, a);
    wr(`NVMDAC_CTRL_OFF, 1'b1, 8'h02);
    wr(`NVMDAC_CTRL_OFF, 1'b1, 8'h03);
    wait_go(0, "fetch_go_clear");
    chk("ctrl_after_fetch", v, 8'h02);
    rd(`NVMDAC_DATA_OFF, 1'b0, v);
    chk("fetched_byte", v, exp);
    rd(`NVMDAC_DATA_OFF, 1'b0, v);
    chk("data_held", v, exp);
  endtask : fetch

  initial begin
    #(100 * 20000);
    errors++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge mclk);
    #1;
    reset = 1'b0;
    chk("mf_irq_after_reset", {7'h00, mf_irq_req}, 8'h00);
    rd(`NVMDAC_BANK_OFF, 1'b0, v);
    chk("bank_reset", v, 8'h00);
    // Write in bank 0 must miss the control register
    wr(`NVMDAC_CTRL_OFF, 1'b1, 8'h02);
    wr(`NVMDAC_BANK_OFF, 1'b0, 8'h01);
    rd(`NVMDAC_CTRL_OFF, 1'b1, v);
    chk("ctrl_reset", v, 8'h00);
    wr(`NVMDAC_CTRL_OFF, 1'b1, 8'h02);
    rd(`NVMDAC_CTRL_OFF, 1'b0, v);
    chk("ctrl_direct_blocked", v, 8'h00);
    wr(`NVMDAC_BANK_OFF, 1'b0, 8'h00);
    rd(`NVMDAC_CTRL_OFF, 1'b1, v);
    chk("ctrl_bank0_hidden", v, 8'h00);
    wr(`NVMDAC_BANK_OFF, 1'b0, 8'h01);
    rd(`NVMDAC_CTRL_OFF, 1'b1, v);
    chk("ctrl_bank1_seen", v, 8'h02);
    wr(`NVMDAC_CTRL_OFF, 1'b1, 8'h00);
    wr(`NVMDAC_ADDR_OFF, 1'b0, 8'hFF);
    rd(`NVMDAC_ADDR_OFF, 1'b0, v);
    chk("addr_width", v, 8'h3F);
    wr(`NVMDAC_ADDR_OFF, 1'b1, 8'h11);
    rd(`NVMDAC_ADDR_OFF, 1'b0, v);
    chk("addr_bank1_blocked", v, 8'h3F);
    rd(8'h55, 1'b0, v);
    chk("unmapped", v, 8'h00);
    wr(`NVMDAC_CTRL_OFF, 1'b1, 8'h01);
    rd(`NVMDAC_CTRL_OFF, 1'b1, v);
    chk("fetch_go_refused", v, 8'h00);
    wr(`NVMDAC_CTRL_OFF, 1'b1, 8'h04);
    rd(`NVMDAC_CTRL_OFF, 1'b1, v);
    chk("prog_go_refused", v, 8'h00);
    chk("no_irq_refused", {7'h00, mf_irq_req}, 8'h00);
    // Arming lost when another access comes between
    wr(`NVMDAC_CTRL_OFF, 1'b1, 8'h08);
    rd(`NVMDAC_ADDR_OFF, 1'b0, v);
    wr(`NVMDAC_CTRL_OFF, 1'b1, 8'h0C);
    rd(`NVMDAC_CTRL_OFF, 1'b1, v);
    chk("store_disarmed", v, 8'h08);
    wr(`NVMDAC_CTRL_OFF, 1'b1, 8'h00);
    store(8'h2A, 8'hA5);
    chk("mf_irq_store", {7'h00, mf_irq_req}, 8'h01);
    rd(`NVMDAC_IRQ_OFF, 1'b0, v);
    chk("irq_flag_store", v, 8'h02);
    mf_enable = 1'b1;
    global_enable = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk("vector_irq_en_off", {7'h00, irq_vector_req}, 8'h00);
    wr(`NVMDAC_IRQ_OFF, 1'b0, 8'h03);
    @(posedge mclk) #1;
    chk("vector_all_on", {7'h00, irq_vector_req}, 8'h01);
    stack_full = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk("vector_stack_full", {7'h00, irq_vector_req}, 8'h00);
    stack_full = 1'b0;
    global_enable = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk("vector_global_off", {7'h00, irq_vector_req}, 8'h00);
    global_enable = 1'b1;
    irq_service_ack = 1'b1;
    @(posedge mclk) #1;
    irq_service_ack = 1'b0;
    chk("mf_irq_serviced", {7'h00, mf_irq_req}, 8'h00);
    rd(`NVMDAC_IRQ_OFF, 1'b0, v);
    chk("irq_flag_kept", v, 8'h03);
    wr(`NVMDAC_IRQ_OFF, 1'b0, 8'h00);
    rd(`NVMDAC_IRQ_OFF, 1'b0, v);
    chk("irq_flag_cleared", v, 8'h00);
    store(8'h3F, 8'h5A);
    // Clear both flags so the fetch must raise them again
    irq_service_ack = 1'b1;
    @(posedge mclk) #1;
    irq_service_ack = 1'b0;
    wr(`NVMDAC_IRQ_OFF, 1'b0, 8'h00);
    wr(`NVMDAC_DATA_OFF, 1'b0, 8'h00);
    // Fetch cut short by clearing its allow bit
    wr(`NVMDAC_ADDR_OFF, 1'b0, 8'h2A);
    wr(`NVMDAC_CTRL_OFF, 1'b1, 8'h02);
    wr(`NVMDAC_CTRL_OFF, 1'b1, 8'h03);
    wr(`NVMDAC_CTRL_OFF, 1'b1, 8'h00);
    rd(`NVMDAC_CTRL_OFF, 1'b1, v);
    chk("ctrl_after_abort", v, 8'h00);
    rd(`NVMDAC_DATA_OFF, 1'b0, v);
    chk("abort_no_data", v, 8'h00);
    chk("abort_no_irq", {7'h00, mf_irq_req}, 8'h00);
    fetch(8'h2A, 8'hA5);
    chk("mf_irq_fetch", {7'h00, mf_irq_req}, 8'h01);
    rd(`NVMDAC_IRQ_OFF, 1'b0, v);
    chk("irq_flag_fetch", v, 8'h02);
    fetch(8'h3F, 8'h5A);
    wr(`NVMDAC_BANK_OFF, 1'b0, 8'h00);
    rd(`NVMDAC_BANK_OFF, 1'b0, v);
    chk("bank_cleared", v, 8'h00);
    conclude();
  end
endmodule : test_nvmdac_top
`default_nettype wire
